// ---- hdl/dpc_defines.vh ----
// register offsets, field positions, reset values and masks of the protection config bank
`ifndef DPC_DEFINES_VH
`define DPC_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DPC_LIMITER_ROUTING_CONFIG_ADDR 8'h23
`define DPC_POWER_LIMIT_CONFIG_ADDR 8'h2B
`define DPC_MIXER_ENABLE_CONFIG_ADDR 8'h2C
`define DPC_PROTECTION_ENABLE_CONFIG_ADDR 8'h2D
`define DPC_BROWNOUT_THRESHOLD_ADDR 8'h2E

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DPC_LIMITER_ROUTING_CONFIG_RST 8'h00
`define DPC_POWER_LIMIT_CONFIG_RST 8'h00
`define DPC_MIXER_ENABLE_CONFIG_RST 8'h00
`define DPC_PROTECTION_ENABLE_CONFIG_RST 8'h00
`define DPC_BROWNOUT_THRESHOLD_RST 8'hBF

// ----------------------------------------------------------------
// writable bit masks (reserved read-only bits stay zero)
// ----------------------------------------------------------------
`define DPC_LIMITER_ROUTING_CONFIG_WMASK 8'hF0
`define DPC_POWER_LIMIT_CONFIG_WMASK 8'hFC
`define DPC_MIXER_ENABLE_CONFIG_WMASK 8'hF0
`define DPC_PROTECTION_ENABLE_CONFIG_WMASK 8'hFF
`define DPC_BROWNOUT_THRESHOLD_WMASK 8'hFF

// ----------------------------------------------------------------
// limiter routing fields
// ----------------------------------------------------------------
`define DPC_LIM_SRC_MSB 7
`define DPC_LIM_SRC_LSB 6
`define DPC_LIM_APPLY_MSB 5
`define DPC_LIM_APPLY_LSB 4
`define DPC_LIM_SRC_MAX 2'h0
`define DPC_LIM_SRC_ONE 2'h1
`define DPC_LIM_SRC_ZERO 2'h2
`define DPC_LIM_SRC_AVG 2'h3
`define DPC_LIM_APPLY_BOTH 2'h0
`define DPC_LIM_APPLY_ONE 2'h1
`define DPC_LIM_APPLY_ZERO 2'h2
`define DPC_LIM_APPLY_NONE 2'h3

// ----------------------------------------------------------------
// power limiter fields
// ----------------------------------------------------------------
`define DPC_PLIM_EN_BIT 7
`define DPC_PLIM_ATTN_MSB 6
`define DPC_PLIM_ATTN_LSB 4
`define DPC_PLIM_ANALOG_BIT 3
`define DPC_PLIM_RECOVER_BIT 2
`define DPC_PLIM_DB_PER_STEP 3'h6

// ----------------------------------------------------------------
// mixer fields
// ----------------------------------------------------------------
`define DPC_MIX_SERIAL_BIT 7
`define DPC_MIX_SIDECHAIN_BIT 6
`define DPC_MIX_LOOPBACK_BIT 4

// ----------------------------------------------------------------
// protection enable fields
// ----------------------------------------------------------------
`define DPC_PROT_DISTORTION_BIT 7
`define DPC_PROT_BATTERY_GUARD_BIT 6
`define DPC_PROT_HEAT_BIT 5
`define DPC_PROT_COMPRESSOR_BIT 4
`define DPC_PROT_SIGGEN1_BIT 3
`define DPC_PROT_SIGGEN2_BIT 2
`define DPC_PROT_SUPPLY_SEL_BIT 1
`define DPC_PROT_UNDERVOLT_BIT 0

// ----------------------------------------------------------------
// undervoltage threshold: code scaled to a 12-bit sample by 16
// ----------------------------------------------------------------
`define DPC_UV_CODE_SHIFT 4

`endif

// ---- hdl/dpc_power_limiter.v ----
// power limiter attenuation tracker with source select and recovery control
`include "dpc_defines.vh"

module dpc_power_limiter #(
    parameter SAMPLE_W = 12
) (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire power_limiter_enable_i,
    input wire [2:0] power_limiter_attenuation_code_i,
    input wire attenuation_from_analog_input_i,
    input wire attenuation_recovery_enable_i,
    input wire plim_request_pin_i,
    input wire analog_sample_valid_i,
    input wire [SAMPLE_W-1:0] analog_sample_i,
    output reg [2:0] plim_attenuation_o
);

    reg [2:0] lut_code;
    reg [2:0] target_code;
    reg [2:0] next_attenuation;

    // ----------------------------------------------------------------
    // lookup: lower input voltage gives deeper attenuation
    // ----------------------------------------------------------------
    always @*
    begin
        lut_code = 3'h7 - analog_sample_i[SAMPLE_W-1:SAMPLE_W-3];
    end

    always @*
    begin
        if (attenuation_from_analog_input_i)
            target_code = analog_sample_valid_i ? lut_code : plim_attenuation_o;
        else if (plim_request_pin_i)
            target_code = power_limiter_attenuation_code_i;
        else
            target_code = 3'h0;
    end

    // ----------------------------------------------------------------
    // attenuation may rise while enabled, falls only with recovery or to zero when disabled
    // ----------------------------------------------------------------
    always @*
    begin
        if (!power_limiter_enable_i)
            next_attenuation = 3'h0;
        else if (target_code > plim_attenuation_o)
            next_attenuation = target_code;
        else if (attenuation_recovery_enable_i)
            next_attenuation = target_code;
        else
            next_attenuation = plim_attenuation_o;
    end

    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            plim_attenuation_o <= 3'h0;
        else
            plim_attenuation_o <= next_attenuation;
    end

endmodule // dpc_power_limiter

// ---- hdl/dpc_protection_config.v ----
// register bank and control decode for playback protection and mixing
`include "dpc_defines.vh"

module dpc_protection_config #(
    parameter LEVEL_W = 16,
    parameter SAMPLE_W = 12
) (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    output reg reg_rvalid_o,
    input wire [LEVEL_W-1:0] playback_input_zero_i,
    input wire [LEVEL_W-1:0] playback_input_one_i,
    output reg [LEVEL_W-1:0] limiter_detect_level_o,
    output wire limiter_apply_zero_o,
    output wire limiter_apply_one_o,
    input wire plim_request_pin_i,
    input wire analog_sample_valid_i,
    input wire [SAMPLE_W-1:0] analog_sample_i,
    output wire [2:0] plim_attenuation_o,
    output reg [5:0] plim_attenuation_db_o,
    output wire serial_playback_mixer_enable_o,
    output wire side_chain_mixer_enable_o,
    output wire loopback_mixer_enable_o,
    output wire distortion_limiter_enable_o,
    output wire battery_guard_enable_o,
    output wire heat_gain_reduction_enable_o,
    output wire range_compressor_enable_o,
    output wire signal_generator_one_enable_o,
    output wire signal_generator_two_enable_o,
    input wire battery_sample_valid_i,
    input wire [SAMPLE_W-1:0] battery_sample_i,
    input wire analog_supply_sample_valid_i,
    input wire [SAMPLE_W-1:0] analog_supply_sample_i,
    output reg supply_measure_valid_o,
    output reg [SAMPLE_W-1:0] supply_measure_o,
    output reg undervoltage_shutdown_o
);

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    reg [7:0] limiter_routing_config;
    reg [7:0] power_limit_config;
    reg [7:0] mixer_enable_config;
    reg [7:0] protection_enable_config;
    reg [7:0] brownout_threshold;
    reg [7:0] next_rdata;

    wire [1:0] limiter_source_select;
    wire [1:0] limiter_apply_select;
    wire power_limiter_enable;
    wire [2:0] power_limiter_attenuation_code;
    wire attenuation_from_analog_input;
    wire attenuation_recovery_enable;
    wire supply_measure_select;
    wire undervoltage_shutdown_enable;
    wire [7:0] undervoltage_threshold_code;
    wire [SAMPLE_W-1:0] threshold_level;
    wire [LEVEL_W:0] level_sum;
    wire sel_valid;
    wire [SAMPLE_W-1:0] sel_sample;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            limiter_routing_config <= `DPC_LIMITER_ROUTING_CONFIG_RST;
            power_limit_config <= `DPC_POWER_LIMIT_CONFIG_RST;
            mixer_enable_config <= `DPC_MIXER_ENABLE_CONFIG_RST;
            protection_enable_config <= `DPC_PROTECTION_ENABLE_CONFIG_RST;
            brownout_threshold <= `DPC_BROWNOUT_THRESHOLD_RST;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                `DPC_LIMITER_ROUTING_CONFIG_ADDR:
                    limiter_routing_config <= reg_wdata_i & `DPC_LIMITER_ROUTING_CONFIG_WMASK;
                `DPC_POWER_LIMIT_CONFIG_ADDR:
                    power_limit_config <= reg_wdata_i & `DPC_POWER_LIMIT_CONFIG_WMASK;
                `DPC_MIXER_ENABLE_CONFIG_ADDR:
                    mixer_enable_config <= reg_wdata_i & `DPC_MIXER_ENABLE_CONFIG_WMASK;
                `DPC_PROTECTION_ENABLE_CONFIG_ADDR:
                    protection_enable_config <= reg_wdata_i & `DPC_PROTECTION_ENABLE_CONFIG_WMASK;
                `DPC_BROWNOUT_THRESHOLD_ADDR:
                    brownout_threshold <= reg_wdata_i & `DPC_BROWNOUT_THRESHOLD_WMASK;
                default:
                begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // register reads, unmapped reads give zero
    // ----------------------------------------------------------------
    always @*
    begin
        case (reg_addr_i)
            `DPC_LIMITER_ROUTING_CONFIG_ADDR:
                next_rdata = limiter_routing_config;
            `DPC_POWER_LIMIT_CONFIG_ADDR:
                next_rdata = power_limit_config;
            `DPC_MIXER_ENABLE_CONFIG_ADDR:
                next_rdata = mixer_enable_config;
            `DPC_PROTECTION_ENABLE_CONFIG_ADDR:
                next_rdata = protection_enable_config;
            `DPC_BROWNOUT_THRESHOLD_ADDR:
                next_rdata = brownout_threshold;
            default:
                next_rdata = 8'h00;
        endcase
    end

    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end
        else
        begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i)
                reg_rdata_o <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // field decode
    // ----------------------------------------------------------------
    assign limiter_source_select = limiter_routing_config[`DPC_LIM_SRC_MSB:`DPC_LIM_SRC_LSB];
    assign limiter_apply_select = limiter_routing_config[`DPC_LIM_APPLY_MSB:`DPC_LIM_APPLY_LSB];
    assign power_limiter_enable = power_limit_config[`DPC_PLIM_EN_BIT];
    assign power_limiter_attenuation_code =
        power_limit_config[`DPC_PLIM_ATTN_MSB:`DPC_PLIM_ATTN_LSB];
    assign attenuation_from_analog_input = power_limit_config[`DPC_PLIM_ANALOG_BIT];
    assign attenuation_recovery_enable = power_limit_config[`DPC_PLIM_RECOVER_BIT];

    assign serial_playback_mixer_enable_o = mixer_enable_config[`DPC_MIX_SERIAL_BIT];
    assign side_chain_mixer_enable_o = mixer_enable_config[`DPC_MIX_SIDECHAIN_BIT];
    assign loopback_mixer_enable_o = mixer_enable_config[`DPC_MIX_LOOPBACK_BIT];

    assign distortion_limiter_enable_o =
        protection_enable_config[`DPC_PROT_DISTORTION_BIT];
    assign battery_guard_enable_o =
        protection_enable_config[`DPC_PROT_BATTERY_GUARD_BIT];
    assign heat_gain_reduction_enable_o =
        protection_enable_config[`DPC_PROT_HEAT_BIT];
    assign range_compressor_enable_o =
        protection_enable_config[`DPC_PROT_COMPRESSOR_BIT];
    assign signal_generator_one_enable_o =
        protection_enable_config[`DPC_PROT_SIGGEN1_BIT];
    assign signal_generator_two_enable_o =
        protection_enable_config[`DPC_PROT_SIGGEN2_BIT];
    assign supply_measure_select = protection_enable_config[`DPC_PROT_SUPPLY_SEL_BIT];
    assign undervoltage_shutdown_enable =
        protection_enable_config[`DPC_PROT_UNDERVOLT_BIT];
    assign undervoltage_threshold_code = brownout_threshold;

    // ----------------------------------------------------------------
    // limiter detection and routing
    // ----------------------------------------------------------------
    assign level_sum = {1'b0, playback_input_zero_i} + {1'b0, playback_input_one_i};

    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            limiter_detect_level_o <= {LEVEL_W{1'b0}};
        else
        begin
            case (limiter_source_select)
                `DPC_LIM_SRC_MAX:
                    limiter_detect_level_o <= (playback_input_zero_i > playback_input_one_i) ?
                        playback_input_zero_i : playback_input_one_i;
                `DPC_LIM_SRC_ONE:
                    limiter_detect_level_o <= playback_input_one_i;
                `DPC_LIM_SRC_ZERO:
                    limiter_detect_level_o <= playback_input_zero_i;
                default:
                    limiter_detect_level_o <= level_sum[LEVEL_W:1];
            endcase
        end
    end

    assign limiter_apply_zero_o = (limiter_apply_select == `DPC_LIM_APPLY_BOTH) ||
        (limiter_apply_select == `DPC_LIM_APPLY_ZERO);
    assign limiter_apply_one_o = (limiter_apply_select == `DPC_LIM_APPLY_BOTH) ||
        (limiter_apply_select == `DPC_LIM_APPLY_ONE);

    // ----------------------------------------------------------------
    // power limiter
    // ----------------------------------------------------------------
    dpc_power_limiter #(
        .SAMPLE_W(SAMPLE_W)
    ) i_dpc_power_limiter (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .power_limiter_enable_i(power_limiter_enable),
        .power_limiter_attenuation_code_i(power_limiter_attenuation_code),
        .attenuation_from_analog_input_i(attenuation_from_analog_input),
        .attenuation_recovery_enable_i(attenuation_recovery_enable),
        .plim_request_pin_i(plim_request_pin_i),
        .analog_sample_valid_i(analog_sample_valid_i),
        .analog_sample_i(analog_sample_i),
        .plim_attenuation_o(plim_attenuation_o)
    );

    // attenuation in dB magnitude, six per step
    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            plim_attenuation_db_o <= 6'h00;
        else
            plim_attenuation_db_o <= plim_attenuation_o * `DPC_PLIM_DB_PER_STEP;
    end

    // ----------------------------------------------------------------
    // supply measurement select and undervoltage shutdown
    // ----------------------------------------------------------------
    assign sel_valid = supply_measure_select ?
        analog_supply_sample_valid_i : battery_sample_valid_i;
    assign sel_sample = supply_measure_select ?
        analog_supply_sample_i : battery_sample_i;
    assign threshold_level =
        {undervoltage_threshold_code, {`DPC_UV_CODE_SHIFT{1'b0}}};

    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            supply_measure_valid_o <= 1'b0;
            supply_measure_o <= {SAMPLE_W{1'b0}};
            undervoltage_shutdown_o <= 1'b0;
        end
        else
        begin
            supply_measure_valid_o <= sel_valid;
            if (sel_valid)
                supply_measure_o <= sel_sample;
            if (!undervoltage_shutdown_enable)
                undervoltage_shutdown_o <= 1'b0;
            else if (sel_valid)
                undervoltage_shutdown_o <= (sel_sample < threshold_level);
        end
    end

endmodule // dpc_protection_config

// ---- verification/dpc_protection_config_bench.sv ----
// self-checking bench for the protection config register bank
`include "dpc_defines.vh"

module dpc_protection_config_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] playback_input_zero_i = 16'h8001;
    logic [15:0] playback_input_one_i = 16'h0003;
    logic plim_request_pin_i = 1'b0;
    logic analog_sample_valid_i = 1'b0;
    logic battery_sample_valid_i = 1'b0;
    logic analog_supply_sample_valid_i = 1'b0;
    logic [11:0] analog_sample_i = 12'h000;
    logic [11:0] battery_sample_i = 12'h000;
    logic [11:0] analog_supply_sample_i = 12'h000;
    wire [7:0] reg_rdata_o;
    wire reg_rvalid_o, limiter_apply_zero_o, limiter_apply_one_o, supply_measure_valid_o;
    wire undervoltage_shutdown_o;
    wire [15:0] limiter_detect_level_o;
    wire [2:0] plim_attenuation_o;
    wire [5:0] plim_attenuation_db_o;
    wire [11:0] supply_measure_o;
    wire serial_playback_mixer_enable_o, side_chain_mixer_enable_o, loopback_mixer_enable_o;
    wire distortion_limiter_enable_o, battery_guard_enable_o, heat_gain_reduction_enable_o;
    wire range_compressor_enable_o, signal_generator_one_enable_o, signal_generator_two_enable_o;
    int fails = 0;
    int comparisons = 0;

    dpc_protection_config i_dpc_protection_config (.*);

    always #50 core_clk_i = ~core_clk_i;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge core_clk_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        repeat (4)
        begin
            @(negedge core_clk_i);
            reg_rd_i = 1'b0;
            if (reg_rvalid_o === 1'b1)
            begin
                check("read data", {8'h00, exp}, {8'h00, reg_rdata_o});
                return;
            end
        end
        fails++;
        $display("ERROR read valid expected 1 seen 0");
        close_out();
    endtask

    // sel 0 analog input, 1 battery, 2 analog supply
    task automatic pulse(input int sel, input logic [11:0] v);
        @(negedge core_clk_i);
        analog_sample_i = v;
        battery_sample_i = v;
        analog_supply_sample_i = v;
        analog_sample_valid_i = (sel == 0);
        battery_sample_valid_i = (sel == 1);
        analog_supply_sample_valid_i = (sel == 2);
        @(negedge core_clk_i);
        {analog_sample_valid_i, battery_sample_valid_i, analog_supply_sample_valid_i} = 3'h0;
        tick(2);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd(`DPC_LIMITER_ROUTING_CONFIG_ADDR, 8'h00);
        rd(`DPC_POWER_LIMIT_CONFIG_ADDR, 8'h00);
        rd(`DPC_MIXER_ENABLE_CONFIG_ADDR, 8'h00);
        rd(`DPC_PROTECTION_ENABLE_CONFIG_ADDR, 8'h00);
        rd(`DPC_BROWNOUT_THRESHOLD_ADDR, 8'hBF);
    endtask

    task automatic t_reserved();
        logic [7:0] addr [5] = '{8'h23, 8'h2B, 8'h2C, 8'h2D, 8'h2E};
        logic [7:0] back [5] = '{8'hF0, 8'hFC, 8'hF0, 8'hFF, 8'hFF};
        foreach (addr[i])
        begin
            wr(addr[i], 8'hFF);
            rd(addr[i], back[i]);
            wr(addr[i], 8'h00);
        end
        wr(8'h24, 8'h5A);
        rd(8'h24, 8'h00);
        rd(`DPC_LIMITER_ROUTING_CONFIG_ADDR, 8'h00);
        wr(`DPC_BROWNOUT_THRESHOLD_ADDR, 8'hBF);
    endtask

    task automatic t_limiter();
        logic [15:0] lvl [4] = '{16'h8001, 16'h0003, 16'h8001, 16'h4002};
        for (int k = 0; k < 4; k++)
        begin
            wr(`DPC_LIMITER_ROUTING_CONFIG_ADDR, {k[1:0], k[1:0], 4'h0});
            tick(2);
            check("detect level", lvl[k], limiter_detect_level_o);
            check("apply zero", {15'h0, !k[0]}, {15'h0, limiter_apply_zero_o});
            check("apply one", {15'h0, !k[1]}, {15'h0, limiter_apply_one_o});
        end
    endtask

    task automatic t_plim();
        wr(`DPC_POWER_LIMIT_CONFIG_ADDR, 8'hB0);
        plim_request_pin_i = 1'b1;
        tick(3);
        check("attn code", 16'h0003, {13'h0, plim_attenuation_o});
        check("attn db", 16'h0012, {10'h0, plim_attenuation_db_o});
        plim_request_pin_i = 1'b0;
        tick(3);
        check("attn hold", 16'h0003, {13'h0, plim_attenuation_o});
        wr(`DPC_POWER_LIMIT_CONFIG_ADDR, 8'hB4);
        tick(3);
        check("attn recover", 16'h0000, {13'h0, plim_attenuation_o});
        wr(`DPC_POWER_LIMIT_CONFIG_ADDR, 8'hF0);
        plim_request_pin_i = 1'b1;
        tick(3);
        check("attn db max", 16'h002A, {10'h0, plim_attenuation_db_o});
        plim_request_pin_i = 1'b0;
        wr(`DPC_POWER_LIMIT_CONFIG_ADDR, 8'h8C);
        pulse(0, 12'h200);
        check("attn lookup", 16'h0006, {13'h0, plim_attenuation_o});
        wr(`DPC_POWER_LIMIT_CONFIG_ADDR, 8'h08);
        tick(3);
        check("attn disabled", 16'h0000, {13'h0, plim_attenuation_o});
    endtask

    task automatic t_enables();
        wr(`DPC_MIXER_ENABLE_CONFIG_ADDR, 8'hD0);
        check("mixers", 16'h0007, {13'h0, serial_playback_mixer_enable_o,
            side_chain_mixer_enable_o, loopback_mixer_enable_o});
        wr(`DPC_MIXER_ENABLE_CONFIG_ADDR, 8'h40);
        check("mixers", 16'h0002, {13'h0, serial_playback_mixer_enable_o,
            side_chain_mixer_enable_o, loopback_mixer_enable_o});
        for (int i = 2; i < 8; i++)
        begin
            wr(`DPC_PROTECTION_ENABLE_CONFIG_ADDR, 8'h01 << i);
            check("protection", 16'h0001 << (i - 2), {10'h0, distortion_limiter_enable_o,
                battery_guard_enable_o, heat_gain_reduction_enable_o,
                range_compressor_enable_o, signal_generator_one_enable_o,
                signal_generator_two_enable_o});
        end
    endtask

    task automatic t_undervolt();
        wr(`DPC_PROTECTION_ENABLE_CONFIG_ADDR, 8'h01);
        pulse(1, 12'hBEF);
        check("shutdown below", 16'h0001, {15'h0, undervoltage_shutdown_o});
        check("measure", 16'h0BEF, {4'h0, supply_measure_o});
        pulse(1, 12'hBF0);
        check("shutdown at", 16'h0000, {15'h0, undervoltage_shutdown_o});
        pulse(2, 12'h100);
        check("other supply", 16'h0000, {15'h0, undervoltage_shutdown_o});
        wr(`DPC_BROWNOUT_THRESHOLD_ADDR, 8'h10);
        wr(`DPC_PROTECTION_ENABLE_CONFIG_ADDR, 8'h03);
        pulse(2, 12'h0FF);
        check("shutdown new", 16'h0001, {15'h0, undervoltage_shutdown_o});
        check("measure", 16'h00FF, {4'h0, supply_measure_o});
        wr(`DPC_PROTECTION_ENABLE_CONFIG_ADDR, 8'h02);
        tick(2);
        check("shutdown off", 16'h0000, {15'h0, undervoltage_shutdown_o});
    endtask

    initial
    begin
        repeat (2) @(posedge core_clk_i);
        @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        t_reset();
        t_reserved();
        t_limiter();
        t_plim();
        t_enables();
        t_undervolt();
        close_out();
    end
endmodule // dpc_protection_config_bench

// ---- verification/dpc_protection_config_properties.sv ----
// concurrent checks on the ports of the protection config bank
`include "dpc_defines.vh"

module dpc_protection_config_properties (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire reg_rvalid_o,
    input wire limiter_apply_zero_o,
    input wire limiter_apply_one_o,
    input wire [2:0] plim_attenuation_o,
    input wire [5:0] plim_attenuation_db_o,
    input wire serial_playback_mixer_enable_o,
    input wire side_chain_mixer_enable_o,
    input wire loopback_mixer_enable_o,
    input wire distortion_limiter_enable_o,
    input wire battery_guard_enable_o,
    input wire heat_gain_reduction_enable_o,
    input wire range_compressor_enable_o,
    input wire signal_generator_one_enable_o,
    input wire signal_generator_two_enable_o,
    input wire battery_sample_valid_i,
    input wire analog_supply_sample_valid_i,
    input wire supply_measure_valid_o,
    input wire undervoltage_shutdown_o
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    wire mapped = (reg_addr_i == `DPC_LIMITER_ROUTING_CONFIG_ADDR) ||
        (reg_addr_i == `DPC_POWER_LIMIT_CONFIG_ADDR) || (reg_addr_i == `DPC_MIXER_ENABLE_CONFIG_ADDR) ||
        (reg_addr_i == `DPC_PROTECTION_ENABLE_CONFIG_ADDR) ||
        (reg_addr_i == `DPC_BROWNOUT_THRESHOLD_ADDR);
    wire any_supply_valid = battery_sample_valid_i || analog_supply_sample_valid_i;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    read_valid_pulse_a: assert property (reg_rvalid_o == $past(reg_rd_i))
        else $error("read valid does not follow read strobe");
    unmapped_read_zero_a: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    apply_decode_a: assert property (reg_wr_i && reg_addr_i == `DPC_LIMITER_ROUTING_CONFIG_ADDR |=>
        limiter_apply_zero_o == !$past(reg_wdata_i[4]) && limiter_apply_one_o == !$past(reg_wdata_i[5]))
        else $error("limiter apply decode wrong");
    mixer_enables_a: assert property (reg_wr_i && reg_addr_i == `DPC_MIXER_ENABLE_CONFIG_ADDR |=>
        {serial_playback_mixer_enable_o, side_chain_mixer_enable_o, loopback_mixer_enable_o} ==
        {$past(reg_wdata_i[7]), $past(reg_wdata_i[6]), $past(reg_wdata_i[4])})
        else $error("mixer enables wrong");
    protect_enables_a: assert property (reg_wr_i && reg_addr_i == `DPC_PROTECTION_ENABLE_CONFIG_ADDR |=>
        {distortion_limiter_enable_o, battery_guard_enable_o, heat_gain_reduction_enable_o,
        range_compressor_enable_o, signal_generator_one_enable_o, signal_generator_two_enable_o}
        == $past(reg_wdata_i[7:2]))
        else $error("protection enables wrong");
    attn_db_scale_a: assert property (plim_attenuation_db_o == {3'h0, $past(plim_attenuation_o)} * 6'h06)
        else $error("attenuation dB not six per step");
    measure_needs_valid_a: assert property (supply_measure_valid_o |-> $past(any_supply_valid))
        else $error("supply measure valid without sample");
    shutdown_on_sample_a: assert property ($rose(undervoltage_shutdown_o) |-> $past(any_supply_valid))
        else $error("shutdown rose without sample");
    shutdown_disable_a: assert property (reg_wr_i && reg_addr_i == `DPC_PROTECTION_ENABLE_CONFIG_ADDR &&
        !reg_wdata_i[0] |-> ##2 !undervoltage_shutdown_o)
        else $error("shutdown stayed after disable");
endmodule // dpc_protection_config_properties

bind dpc_protection_config dpc_protection_config_properties i_dpc_protection_config_properties (.*);
